// ### common/rtg_pkg.sv
// Constants, types and the function list of the repeated trigger generator.
// Function
// - Run request starts triggers, self-clears when finished.
// - Consecutive triggers separated by programmed hold-off, never below 2 cycles.
// - Exactly the programmed 64-bit count per run.
// - Read-only progress equals issued over count.
// - Gate holds first trigger until workers ready.
// - Gate enabled repeats runs with unchanged settings.
// - Read-only internal clock frequency in hertz.
package rtg_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam logic [63:0] RTG_CLK_FREQ_HZ = 64'h0000_0000_0beb_c200;
  // Shortest trigger spacing the state machine can serve
  localparam logic [63:0] RTG_GAP_MIN = 64'h0000_0000_0000_0002;

  // ----------------------------------------------------------------
  // Progress fraction format: one integer bit, 32 fraction bits
  // ----------------------------------------------------------------
  localparam int RTG_FRAC_W = 32;
  localparam logic [32:0] RTG_PROG_ZERO = 33'h0_0000_0000;
  localparam logic [32:0] RTG_PROG_ONE = 33'h1_0000_0000;
  localparam logic [5:0] RTG_DIV_LAST = 6'h1f;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [63:0] RTG_CNT_RST = 64'h0;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RTG_ST_IDLE = 2'h0,
    RTG_ST_SYNC = 2'h1,
    RTG_ST_FIRE = 2'h2,
    RTG_ST_GAP = 2'h3
  } rtg_state_t;

  // Whole state of the sequencer
  typedef struct packed {
    rtg_state_t st;
    logic runReq;
    logic trig;
    logic [63:0] gapLat;
    logic [63:0] cntLat;
    logic [63:0] issued;
    logic [63:0] gapCnt;
    logic [32:0] prog;
    logic progFinal;
    logic divRun;
    logic [63:0] divNumer;
  } rtg_seq_t;

  // Whole state of the fraction divider
  typedef struct packed {
    logic busy;
    logic done;
    logic [5:0] cnt;
    logic [64:0] rem;
    logic [63:0] denom;
    logic [31:0] quot;
  } rtg_div_t;

endpackage

// ### common/rtg_div_if.sv
// Request and answer bundle between the sequencer and the fraction divider.
`timescale 1ns/1ps
interface rtg_div_if;
  logic start;
  logic [63:0] numer;
  logic [63:0] denom;
  logic busy;
  logic done;
  logic [31:0] quot;

  modport req (output start, output numer, output denom, input busy, input done, input quot);
  modport srv (input start, input numer, input denom, output busy, output done, output quot);
endinterface

// ### rtl/rtg_frac_div.sv
// Sequential divider giving numer/denom as a 32-bit binary fraction.
`timescale 1ns/1ps
module rtg_frac_div
  import rtg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  rtg_div_if.srv div
);

  rtg_div_t r_r;
  rtg_div_t r_nxt;
  logic [64:0] shifted;

  // ----------------------------------------------------------------
  // Restoring division, one quotient bit per cycle
  // ----------------------------------------------------------------
  // Caller keeps numer below denom, so the remainder never overflows 65 bits
  always_comb
  begin
    r_nxt = r_r;
    r_nxt.done = 1'b0;
    shifted = {r_r.rem[63:0], 1'b0};
    if (!r_r.busy && div.start)
    begin
      r_nxt.busy = 1'b1;
      r_nxt.cnt = 6'h00;
      r_nxt.rem = {1'b0, div.numer};
      r_nxt.denom = div.denom;
      r_nxt.quot = 32'h0;
    end
    else if (r_r.busy)
    begin
      if (shifted >= {1'b0, r_r.denom})
      begin
        r_nxt.rem = shifted - {1'b0, r_r.denom};
        r_nxt.quot = {r_r.quot[30:0], 1'b1};
      end
      else
      begin
        r_nxt.rem = shifted;
        r_nxt.quot = {r_r.quot[30:0], 1'b0};
      end
      r_nxt.cnt = r_r.cnt + 6'h01;
      if (r_r.cnt == RTG_DIV_LAST)
      begin
        r_nxt.busy = 1'b0;
        r_nxt.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  assign div.busy = r_r.busy;
  assign div.done = r_r.done;
  assign div.quot = r_r.quot;

endmodule // rtg_frac_div

// ### rtl/rtg_top.sv
// Repeated trigger generator: run control, hold-off spacing, sync gate, progress.
`timescale 1ns/1ps
module rtg_top
  import rtg_pkg::*;
#(
  parameter int NUM_WORKERS = 8
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic runReqSet,
  input wire logic runReqClr,
  input wire logic [63:0] triggerGapCycles,
  input wire logic [63:0] triggerCountTarget,
  input wire logic workerReadyGate,
  input wire logic [NUM_WORKERS-1:0] workerConnected,
  input wire logic [NUM_WORKERS-1:0] workerReady,
  output logic triggerRunRequest,
  output logic triggerPulse,
  output logic syncWaiting,
  output logic [63:0] triggersIssued,
  output logic [32:0] doneFraction,
  output logic [63:0] clockFreqHz
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NUM_WORKERS < 1)
  begin : g_chk
    $error("NUM_WORKERS must be at least one");
  end

  rtg_seq_t r_r;
  rtg_seq_t r_nxt;
  logic [NUM_WORKERS-1:0] workerOk;
  logic allReady;
  logic [63:0] issuedInc;
  logic [63:0] gapUse;

  rtg_div_if divBus ();

  rtg_frac_div u_div (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .div(divBus)
  );

  // ----------------------------------------------------------------
  // Worker readiness
  // ----------------------------------------------------------------
  // Unconnected workers count as ready so a partial system still runs
  for (genvar w = 0; w < NUM_WORKERS; w++)
  begin : g_wrk
    assign workerOk[w] = workerReady[w] | ~workerConnected[w];
  end
  assign allReady = &workerOk;

  assign issuedInc = r_r.issued + 64'h1;
  // Spacings below the minimum are stretched, never shortened
  assign gapUse = (r_r.gapLat < RTG_GAP_MIN) ? RTG_GAP_MIN : r_r.gapLat;

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb
  begin
    r_nxt = r_r;
    r_nxt.trig = 1'b0;
    case (r_r.st)
      RTG_ST_IDLE:
      begin
        if (r_r.runReq)
        begin
          // Settings are frozen here and reused by every repeat
          r_nxt.gapLat = triggerGapCycles;
          r_nxt.cntLat = triggerCountTarget;
          r_nxt.issued = RTG_CNT_RST;
          r_nxt.prog = RTG_PROG_ZERO;
          r_nxt.progFinal = 1'b0;
          r_nxt.divRun = 1'b0;
          r_nxt.divNumer = RTG_CNT_RST;
          if (triggerCountTarget == RTG_CNT_RST)
          begin
            // Empty run finishes at once
            r_nxt.runReq = 1'b0;
            r_nxt.prog = RTG_PROG_ONE;
            r_nxt.progFinal = 1'b1;
          end
          else if (workerReadyGate)
            r_nxt.st = RTG_ST_SYNC;
          else
            r_nxt.st = RTG_ST_FIRE;
        end
      end
      RTG_ST_SYNC:
      begin
        if (!workerReadyGate || runReqClr)
          r_nxt.st = RTG_ST_IDLE;
        else if (allReady)
        begin
          // New repeat with the same frozen settings
          r_nxt.st = RTG_ST_FIRE;
          r_nxt.runReq = 1'b1;
          r_nxt.issued = RTG_CNT_RST;
          r_nxt.prog = RTG_PROG_ZERO;
          r_nxt.progFinal = 1'b0;
          r_nxt.divRun = 1'b0;
          r_nxt.divNumer = RTG_CNT_RST;
        end
      end
      RTG_ST_FIRE:
      begin
        r_nxt.trig = 1'b1;
        r_nxt.issued = issuedInc;
        if (issuedInc == r_r.cntLat)
        begin
          r_nxt.runReq = 1'b0;
          r_nxt.prog = RTG_PROG_ONE;
          r_nxt.progFinal = 1'b1;
          r_nxt.st = workerReadyGate ? RTG_ST_SYNC : RTG_ST_IDLE;
        end
        else
        begin
          r_nxt.gapCnt = gapUse - 64'h1;
          r_nxt.st = RTG_ST_GAP;
        end
      end
      RTG_ST_GAP:
      begin
        r_nxt.gapCnt = r_r.gapCnt - 64'h1;
        if (r_r.gapCnt <= 64'h1)
          r_nxt.st = RTG_ST_FIRE;
      end
      default:
        r_nxt.st = RTG_ST_IDLE;
    endcase

    // Software abort of a run in flight
    if (runReqClr && (r_r.st == RTG_ST_FIRE || r_r.st == RTG_ST_GAP))
    begin
      r_nxt.st = RTG_ST_IDLE;
      r_nxt.trig = 1'b0;
    end

    // Progress refresh; stale answers from an earlier run are dropped
    divBus.start = 1'b0;
    // Nothing is started or taken while idle, so a restart never sees an old answer
    if (!divBus.busy && !r_r.progFinal && r_r.issued != r_r.divNumer
        && r_r.st != RTG_ST_IDLE)
    begin
      divBus.start = 1'b1;
      r_nxt.divNumer = r_r.issued;
      r_nxt.divRun = 1'b1;
    end
    if (divBus.done && r_r.divRun && !r_r.progFinal && !r_nxt.progFinal
        && r_r.st != RTG_ST_IDLE)
      r_nxt.prog = {1'b0, divBus.quot};

    // Software write applied last: a set wins over the self-clear
    if (runReqSet)
      r_nxt.runReq = 1'b1;
    else if (runReqClr)
      r_nxt.runReq = 1'b0;
  end

  assign divBus.numer = r_r.issued;
  assign divBus.denom = r_r.cntLat;

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign triggerRunRequest = r_r.runReq;
  assign triggerPulse = r_r.trig;
  assign syncWaiting = (r_r.st == RTG_ST_SYNC);
  assign triggersIssued = r_r.issued;
  assign doneFraction = r_r.prog;
  assign clockFreqHz = RTG_CLK_FREQ_HZ;

endmodule // rtg_top

// ### test/rtg_checker.sv
// Port assertions of the repeated trigger generator
`timescale 1ns/1ps
module rtg_checker
  import rtg_pkg::*;
#(
  parameter int NUM_WORKERS = 8
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic runReqSet,
  input wire logic runReqClr,
  input wire logic [63:0] triggerGapCycles,
  input wire logic [63:0] triggerCountTarget,
  input wire logic workerReadyGate,
  input wire logic [NUM_WORKERS-1:0] workerConnected,
  input wire logic [NUM_WORKERS-1:0] workerReady,
  input wire logic triggerRunRequest,
  input wire logic triggerPulse,
  input wire logic syncWaiting,
  input wire logic [63:0] triggersIssued,
  input wire logic [32:0] doneFraction
);
  // ----
  // Helpers
  // ----
  logic [63:0] sinceCnt_r;
  logic allReady;
  logic [63:0] gapExp;
  // Unconnected workers never block the gate
  assign allReady = &(workerReady | ~workerConnected);
  assign gapExp = (triggerGapCycles < RTG_GAP_MIN) ? RTG_GAP_MIN : triggerGapCycles;
  // Cycles since last trigger; bench holds the gap steady during a run
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      sinceCnt_r <= 64'h0;
    else
      sinceCnt_r <= triggerPulse ? 64'h1 : sinceCnt_r + 64'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ----
  // Properties
  // ----
  sequence s_ready; syncWaiting && allReady && workerReadyGate && !runReqClr; endsequence
  sequence s_fire; ##2 triggerPulse; endsequence
  property p_set; runReqSet |=> triggerRunRequest; endproperty
  a_set: assert property (p_set) else $error("set lost");
  property p_idle; !$past(triggerRunRequest) |-> !triggerPulse; endproperty
  a_idle: assert property (p_idle) else $error("pulse while idle");
  property p_one; triggerPulse |=> !triggerPulse; endproperty
  a_one: assert property (p_one) else $error("pulse too wide");
  property p_gap; triggerPulse && triggersIssued > 64'h1 |-> sinceCnt_r == gapExp; endproperty
  a_gap: assert property (p_gap) else $error("bad spacing");
  property p_inc;
    triggerPulse && triggersIssued != 64'h1 |-> triggersIssued == $past(triggersIssued) + 64'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("bad issue count");
  property p_last;
    triggerPulse && triggersIssued == triggerCountTarget
      |-> !triggerRunRequest && doneFraction == RTG_PROG_ONE;
  endproperty
  a_last: assert property (p_last) else $error("bad run end");
  property p_go; s_ready |-> s_fire; endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_hold; syncWaiting && !allReady && workerReadyGate && !runReqClr |=> syncWaiting; endproperty
  a_hold: assert property (p_hold) else $error("left wait early");
  // Only a completed run re-arms the wait; a software clear ends the gate loop
  property p_rep;
    triggerPulse && !triggerRunRequest && $past(workerReadyGate) |-> syncWaiting;
  endproperty
  a_rep: assert property (p_rep) else $error("no repeat wait");
endmodule // rtg_checker

// ### test/rtg_worker_model.sv
// Behavioural set of worker instruments reporting ready
`timescale 1ns/1ps
module rtg_worker_model #(
  parameter int NUM_WORKERS = 8
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic prepare,
  input wire logic [7:0] lagCyc,
  output logic [NUM_WORKERS-1:0] workerReady
);
  logic [7:0] age_r;
  // Age since prepare, saturating so ready never drops by wrap
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      age_r <= 8'h0;
    else
      age_r <= prepare ? age_r + {7'h0, age_r != 8'hff} : 8'h0;
  end
  // Worker i is ready lagCyc+i cycles later, so the last one gates
  always_comb
  begin
    for (int i = 0; i < NUM_WORKERS; i++)
      workerReady[i] = prepare && (age_r >= lagCyc + 8'(i));
  end
endmodule // rtg_worker_model

// ### test/repeated_trigger_generator_bench.sv
// Self-checking bench of the repeated trigger generator
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
bind rtg_top rtg_checker #(.NUM_WORKERS(NUM_WORKERS)) chk_u (.clk_sys, .rstn, .runReqSet,
  .runReqClr, .triggerGapCycles, .triggerCountTarget, .workerReadyGate, .workerConnected,
  .workerReady, .triggerRunRequest, .triggerPulse, .syncWaiting, .triggersIssued, .doneFraction);
module repeated_trigger_generator_bench
  import rtg_pkg::*;
();
  logic clk_sys = 1'b0, rstn = 1'b0, runReqSet = 1'b0, runReqClr = 1'b0;
  logic workerReadyGate = 1'b0, prepare = 1'b0;
  logic [63:0] triggerGapCycles = 64'h0, triggerCountTarget = 64'h0;
  logic [7:0] workerConnected = 8'h7f;
  logic triggerRunRequest, triggerPulse, syncWaiting;
  logic [63:0] triggersIssued, clockFreqHz;
  logic [7:0] workerReady;
  logic [32:0] doneFraction;
  int errors = 0, check_count = 0, cycles = 0, pulseTot = 0;
  rtg_top #(.NUM_WORKERS(8)) dut_u (.clk_sys, .rstn, .runReqSet, .runReqClr,
    .triggerGapCycles, .triggerCountTarget, .workerReadyGate, .workerConnected, .workerReady,
    .triggerRunRequest, .triggerPulse, .syncWaiting, .triggersIssued, .doneFraction, .clockFreqHz);
  rtg_worker_model #(.NUM_WORKERS(8)) wrk_u (.clk_sys, .rstn, .prepare, .lagCyc(8'h5),
    .workerReady);
  // ----
  // Clock, pulse tally and hang guard
  // ----
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    pulseTot += int'(triggerPulse === 1'b1);
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_start(logic [63:0] gap, logic [63:0] cnt);
    @(posedge clk_sys);
    triggerGapCycles <= gap;
    triggerCountTarget <= cnt;
    runReqSet <= 1'b1;
    @(posedge clk_sys);
    runReqSet <= 1'b0;
    @(negedge clk_sys);
  endtask
  // Full run; count 0 is the empty run that completes at once with no pulse at all
  task automatic t_run(logic [63:0] gap, logic [63:0] cnt);
    int base;
    base = pulseTot;
    t_start(gap, cnt);
    wait (triggerRunRequest === 1'b0);
    repeat (2) @(negedge clk_sys);
    `CHK("pulses", cnt, 64'(pulseTot - base))
    `CHK("issued", cnt, triggersIssued)
    `CHK("fraction", RTG_PROG_ONE, doneFraction)
    `CHK("freq", RTG_CLK_FREQ_HZ, clockFreqHz)
  endtask
  // Half-way progress, then an abort stops further triggers
  task automatic t_abort();
    t_start(64'd100, 64'd4);
    wait (triggersIssued === 64'd2);
    repeat (60) @(negedge clk_sys);
    `CHK("half", 33'h0_8000_0000, doneFraction)
    @(posedge clk_sys);
    runReqClr <= 1'b1;
    @(posedge clk_sys);
    runReqClr <= 1'b0;
    repeat (150) @(negedge clk_sys);
    `CHK("abort rr", 1'b0, triggerRunRequest)
    `CHK("abort issued", 64'd2, triggersIssued)
  endtask
  // Gate holds the start, repeats the run, stops once cleared
  task automatic t_sync();
    int base;
    base = pulseTot;
    @(posedge clk_sys);
    workerReadyGate <= 1'b1;
    t_start(64'd2, 64'd3);
    repeat (40) @(negedge clk_sys);
    `CHK("held", 0, pulseTot - base)
    `CHK("waiting", 1'b1, syncWaiting)
    @(posedge clk_sys);
    prepare <= 1'b1;
    wait (triggerRunRequest === 1'b0);
    wait (triggerRunRequest === 1'b1);
    @(posedge clk_sys);
    workerReadyGate <= 1'b0;
    wait (triggerRunRequest === 1'b0);
    repeat (20) @(negedge clk_sys);
    `CHK("repeat", 6, pulseTot - base)
    `CHK("stopped", 1'b0, syncWaiting)
    `CHK("rr off", 1'b0, triggerRunRequest)
  endtask
  // A software clear ends the wait; a cleared gate lets the held run go ahead
  task automatic t_sync_exit();
    int base;
    base = pulseTot;
    @(posedge clk_sys);
    prepare <= 1'b0;
    workerReadyGate <= 1'b1;
    t_start(64'd2, 64'd1);
    repeat (5) @(negedge clk_sys);
    `CHK("wait clr", 1'b1, syncWaiting)
    @(posedge clk_sys);
    runReqClr <= 1'b1;
    @(posedge clk_sys);
    runReqClr <= 1'b0;
    repeat (3) @(negedge clk_sys);
    `CHK("clr left", 1'b0, syncWaiting)
    `CHK("clr rr", 1'b0, triggerRunRequest)
    `CHK("clr pulses", 0, pulseTot - base)
    base = pulseTot;
    t_start(64'd2, 64'd1);
    repeat (5) @(negedge clk_sys);
    `CHK("wait gate", 1'b1, syncWaiting)
    @(posedge clk_sys);
    workerReadyGate <= 1'b0;
    wait (triggerRunRequest === 1'b0);
    repeat (3) @(negedge clk_sys);
    `CHK("gate off", 1'b0, syncWaiting)
    `CHK("gate pulses", 1, pulseTot - base)
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    t_run(64'd3, 64'd2);
    t_run(64'd1, 64'd3);
    t_run(64'd0, 64'd0);
    t_abort();
    t_sync();
    t_sync_exit();
    test_done();
  end
endmodule // repeated_trigger_generator_bench
